//--- sar_adc_sequencer.sv
// Sequencer for the ten-bit successive-approximation converter.
// Assumes clk is the machine-cycle clock and clkEn is low in power-down.
`timescale 1ns/1ps
module sar_adc_sequencer
  import sar_adc_pkg::*;
#(
  parameter int Width = ResultBits
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             clkEn,
  input  wire sfrReq_t          sfrReq,
  output logic      [7:0]       sfrRdata,
  input  wire logic             external_start_pin,
  input  wire logic             idleMode,
  input  wire logic             cmpAbove,
  input  wire logic             intEnable,
  output logic      [Width-1:0] dacCode,
  output logic      [2:0]       analogMuxSel,
  output logic      [7:0]       analog_input_port_sel,
  output logic                  sampleHold,
  output logic                  convIrq
);

  // Bit counter wide enough for the longest phase
  localparam int CntW = 4;
  localparam logic [CntW-1:0] InitLast   = CntW'(InitCycles - 1);
  localparam logic [CntW-1:0] SampleLast = CntW'(SampleCycles - 1);
  localparam logic [CntW-1:0] BitLast    = CntW'(CyclesPerBit - 1);

  function automatic logic isWrite(input sfrReq_t r, input logic [7:0] a);
    return r.wr && (r.addr == a);
  endfunction

  seqState_t        state_q, state_d;
  logic [CntW-1:0]  cnt_q, cnt_d;
  logic [Width-1:0] sar_q, sar_d;
  logic [Width-1:0] mask_q, mask_d;
  logic [Width-1:0] result_q, result_d;
  logic             extEn_q, extEn_d;
  logic             done_q, done_d;
  logic             busy_q, busy_d;
  logic             cmd_q, cmd_d;
  logic [2:0]       chan_q, chan_d;
  logic             pinPrev_q, pinPrev_d;

  logic             ctrlWr;
  logic             swStart;
  logic             pinRise;
  logic             startReq;
  logic [Width-1:0] stepSar;
  logic [Width-1:0] stepMask;

  sar_step #(
    .Width (Width)
  ) u_step (
    .sarIn    (sar_q),
    .bitMask  (mask_q),
    .cmpAbove (cmpAbove),
    .sarOut   (stepSar),
    .nextMask (stepMask)
  );

  // Start sources; the pin edge is seen at the end of a machine cycle
  always_comb begin
    ctrlWr   = isWrite(sfrReq, CtrlRegAddr);
    swStart  = ctrlWr && sfrReq.wdata[StartPos];
    pinRise  = extEn_q && external_start_pin && !pinPrev_q;
    startReq = (swStart || pinRise) && !busy_q && !cmd_q && !done_q;
  end

  // Register-side state: control fields, done flag, command flip-flop
  always_comb begin
    extEn_d   = extEn_q;
    chan_d    = chan_q;
    done_d    = done_q;
    cmd_d     = cmd_q;
    pinPrev_d = external_start_pin;
    if (ctrlWr) begin
      extEn_d = sfrReq.wdata[ExtEnPos];
      // Channel is only steered while the converter is quiet
      if (!busy_q && !cmd_q && !done_q) begin
        chan_d = sfrReq.wdata[ChanMsbPos:ChanLsbPos];
      end
      // Software may clear the flag, never set it
      if (!sfrReq.wdata[DonePos]) begin
        done_d = 1'b0;
      end
    end
    if (startReq) begin
      cmd_d = 1'b1;
    end
    if (state_q == StInit) begin
      cmd_d = 1'b0;
    end
    // Hardware set wins over a same-cycle software clear
    if (state_q == StConv && cnt_q == BitLast && mask_q[0]) begin
      done_d = 1'b1;
    end
    if (idleMode) begin
      cmd_d = 1'b0;
    end
  end

  // Conversion sequence: init, sample, then ten bit periods
  always_comb begin
    state_d  = state_q;
    cnt_d    = cnt_q;
    sar_d    = sar_q;
    mask_d   = mask_q;
    result_d = result_q;
    busy_d   = busy_q;
    case (state_q)
      StIdle: begin
        if (cmd_q && !idleMode) begin
          state_d = StInit;
          cnt_d   = '0;
        end
      end
      StInit: begin
        busy_d = 1'b1;
        if (cnt_q == InitLast) begin
          state_d = StSample;
          cnt_d   = '0;
        end else begin
          cnt_d = cnt_q + 1'b1;
        end
      end
      StSample: begin
        if (cnt_q == SampleLast) begin
          state_d = StConv;
          cnt_d   = '0;
          sar_d   = SarMsbOnly;
          mask_d  = SarMsbOnly;
        end else begin
          cnt_d = cnt_q + 1'b1;
        end
      end
      StConv: begin
        if (cnt_q == BitLast) begin
          cnt_d  = '0;
          sar_d  = stepSar;
          mask_d = stepMask;
          if (mask_q[0]) begin
            // Straight binary code straight from the approximation register
            result_d = stepSar;
            busy_d   = 1'b0;
            state_d  = StIdle;
          end
        end else begin
          cnt_d = cnt_q + 1'b1;
        end
      end
      default: begin
        state_d = StIdle;
        busy_d  = 1'b0;
      end
    endcase
    // Idle mode drops a running conversion and keeps the old result
    if (idleMode && state_q != StIdle) begin
      state_d = StIdle;
      busy_d  = 1'b0;
      cnt_d   = '0;
    end
  end

  // All state frozen while clkEn is low, which models power-down
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q   <= StIdle;
      cnt_q     <= '0;
      sar_q     <= SarZero;
      mask_q    <= SarZero;
      result_q  <= SarZero;
      extEn_q   <= CtrlResetVal[ExtEnPos];
      done_q    <= CtrlResetVal[DonePos];
      busy_q    <= CtrlResetVal[StartPos];
      cmd_q     <= 1'b0;
      chan_q    <= CtrlResetVal[ChanMsbPos:ChanLsbPos];
      pinPrev_q <= 1'b1;
    end else if (clkEn) begin
      state_q   <= state_d;
      cnt_q     <= cnt_d;
      sar_q     <= sar_d;
      mask_q    <= mask_d;
      result_q  <= result_d;
      extEn_q   <= extEn_d;
      done_q    <= done_d;
      busy_q    <= busy_d;
      cmd_q     <= cmd_d;
      chan_q    <= chan_d;
      pinPrev_q <= pinPrev_d;
    end
  end

  // Read data; start bit shows the busy flip-flop, not the command
  always_comb begin
    sfrRdata = 8'h00;
    if (sfrReq.rd && sfrReq.addr == CtrlRegAddr) begin
      sfrRdata[ResBit1Pos]            = result_q[1];
      sfrRdata[ResBit0Pos]            = result_q[0];
      sfrRdata[ExtEnPos]              = extEn_q;
      sfrRdata[DonePos]               = done_q;
      sfrRdata[StartPos]              = busy_q;
      sfrRdata[ChanMsbPos:ChanLsbPos] = chan_q;
    end else if (sfrReq.rd && sfrReq.addr == ResultHighAddr) begin
      sfrRdata = result_q[Width-1:Width-8];
    end
  end

  // Analog-side drive and interrupt request
  always_comb begin
    dacCode               = sar_q;
    analogMuxSel          = chan_q;
    analog_input_port_sel = 8'h01 << chan_q;
    sampleHold            = (state_q == StSample);
    convIrq               = done_q && intEnable;
  end

endmodule

//--- sar_adc_pkg.sv
// Constants, field layout and carrier types for the converter sequencer.
// Assumes an 8-bit special-function-register port driven by the CPU core.
// How it works
// - Four machine cycles per result bit
// - External enable low: software start only
// - External enable high: software or rising pin
// - Done flag set at result; interrupt if enabled
// - Writing one to done flag does nothing
// - Start write or pin sets start bit
// - Start bit reads one while busy
// - Busy clears as done flag sets
// - Starts ignored while busy or done
// - Straight binary result, 000 to 3ff
// - Idle mode aborts running conversion
// - Power-down freezes logic, keeps registers
// - Test bits from MSB downward, keep if above
// - High eight bits separate, low two in control
// - Three select bits pick one input
package sar_adc_pkg;

  localparam logic [7:0] CtrlRegAddr   = 8'hc5;  // converter_control_reg
  localparam logic [7:0] ResultHighAddr = 8'hc6; // result_high_reg
  localparam logic [7:0] CtrlResetVal  = 8'h00;

  // Field positions in the control register
  localparam int ResBit1Pos   = 7;
  localparam int ResBit0Pos   = 6;
  localparam int ExtEnPos     = 5;
  localparam int DonePos      = 4;
  localparam int StartPos     = 3;
  localparam int ChanMsbPos   = 2;
  localparam int ChanLsbPos   = 0;

  // Timing: setup cycles before sampling, sample cycles, cycles per bit
  localparam int ResultBits     = 10;
  localparam int CyclesPerBit   = 4;
  localparam int InitCycles     = 2;
  localparam int SampleCycles   = 8;

  localparam logic [9:0] SarMsbOnly = 10'h200;
  localparam logic [9:0] SarZero    = 10'h000;

  typedef enum logic [3:0] {
    StIdle   = 4'b0001,
    StInit   = 4'b0010,
    StSample = 4'b0100,
    StConv   = 4'b1000
  } seqState_t;

  // Register-port request carrier
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sfrReq_t;

endpackage

//--- sar_step.sv
// One successive-approximation step: resolve the tested bit, raise the next.
// Assumes the comparator output is valid at the end of the bit period.
`timescale 1ns/1ps
module sar_step
  import sar_adc_pkg::*;
#(
  parameter int Width = ResultBits
) (
  input  wire logic [Width-1:0] sarIn,
  input  wire logic [Width-1:0] bitMask,
  input  wire logic             cmpAbove,
  output logic      [Width-1:0] sarOut,
  output logic      [Width-1:0] nextMask
);

  // Keep the tested bit only if the input exceeds the ladder, set the next one
  always_comb begin
    sarOut   = cmpAbove ? sarIn : (sarIn & ~bitMask);
    nextMask = bitMask >> 1;
    sarOut   = sarOut | nextMask;
  end

endmodule

//--- sar_adc_sequencer_assertions.sv
// Port-level assertions for the converter sequencer.
// Assumes clkEn stays high while sampling and during the first bit period.
`timescale 1ns/1ps
module sar_adc_sequencer_assertions
  import sar_adc_pkg::*;
#(
  parameter int Width = ResultBits
) (
  input wire logic             clk,
  input wire logic             rst_n,
  input wire logic             clkEn,
  input wire sfrReq_t          sfrReq,
  input wire logic [7:0]       sfrRdata,
  input wire logic             intEnable,
  input wire logic [Width-1:0] dacCode,
  input wire logic [2:0]       analogMuxSel,
  input wire logic [7:0]       analog_input_port_sel,
  input wire logic             sampleHold,
  input wire logic             convIrq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic rdCtrl;
  // Control register read in progress
  assign rdCtrl = sfrReq.rd && sfrReq.addr == CtrlRegAddr;
  a_irq_gate: assert property (!intEnable |-> !convIrq)
    else $error("irq raised while disabled");
  a_irq_hold: assert property (convIrq && clkEn && !sfrReq.wr |=> convIrq || !intEnable)
    else $error("irq dropped without clear");
  a_mux_onehot: assert property (analog_input_port_sel == 8'h01 << analogMuxSel)
    else $error("input select not one-hot of channel");
  a_freeze_hold: assert property (!clkEn |=> $stable(dacCode) && $stable(analogMuxSel))
    else $error("state moved while frozen");
  a_sample_len: assert property ($rose(sampleHold) |-> sampleHold[*8] ##1 !sampleHold)
    else $error("sample window length wrong");
  a_msb_first: assert property ($fell(sampleHold) |-> dacCode == SarMsbOnly)
    else $error("first trial code wrong");
  a_bit_period: assert property ($fell(sampleHold) |-> ##1 $stable(dacCode)[*3] ##1 !$stable(dacCode))
    else $error("bit period not four cycles");
  a_done_read: assert property (rdCtrl && convIrq |-> sfrRdata[DonePos])
    else $error("irq without done flag");
  a_busy_done: assert property (rdCtrl |-> !(sfrRdata[StartPos] && sfrRdata[DonePos]))
    else $error("busy and done both set");
  c_conv: cover property ($fell(sampleHold));
  c_irq: cover property (convIrq);
  c_freeze: cover property (!clkEn);
endmodule

bind sar_adc_sequencer sar_adc_sequencer_assertions #(.Width(Width)) chk (.clk(clk),
  .rst_n(rst_n), .clkEn(clkEn), .sfrReq(sfrReq), .sfrRdata(sfrRdata), .intEnable(intEnable),
  .dacCode(dacCode), .analogMuxSel(analogMuxSel), .analog_input_port_sel(analog_input_port_sel),
  .sampleHold(sampleHold), .convIrq(convIrq));

//--- analog_input_model.sv
// Comparator model of the analog side: input level against trial code.
// Assumes vinLevel is in code steps; 11'h400 stands for full scale.
`timescale 1ns/1ps
module analog_input_model (
  input  wire logic [9:0]  dacCode,
  input  wire logic [10:0] vinLevel,
  output logic             cmpAbove
);
  // Strictly greater, so a level of zero never keeps a bit
  assign cmpAbove = {1'b0, dacCode} < vinLevel;
endmodule

//--- tb_sar_adc_sequencer.sv
// Self-checking bench for the converter sequencer.
// Assumes the comparator model and the bound checker.
`timescale 1ns/1ps
module tb_sar_adc_sequencer
  import sar_adc_pkg::*;
;
  logic clk = 0, rst_n = 0, clkEn = 1, pin = 0, idleMode = 0, intEnable = 0;
  logic cmp, sh, irq;
  logic [7:0] rdata, q, r, portSel;
  logic [9:0] dac;
  logic [2:0] muxSel;
  logic [10:0] vinLevel = 11'h000;
  sfrReq_t req = '0;
  int failures = 0, numChecks = 0;

  always #20 clk = ~clk;

  analog_input_model u_ana (.dacCode(dac), .vinLevel(vinLevel), .cmpAbove(cmp));
  sar_adc_sequencer DUT (.clk(clk), .rst_n(rst_n), .clkEn(clkEn), .sfrReq(req),
    .sfrRdata(rdata), .external_start_pin(pin), .idleMode(idleMode), .cmpAbove(cmp),
    .intEnable(intEnable), .dacCode(dac), .analogMuxSel(muxSel),
    .analog_input_port_sel(portSel), .sampleHold(sh), .convIrq(irq));

  task check(input string what, input logic [9:0] exp, input logic [9:0] got);
    numChecks++;
    if (got !== exp) begin
      failures++;
      $display("wrong value %0s expected %h seen %h", what, exp, got);
    end
  endtask

  task wrap_up;
    $display("checks %0d failures %0d", numChecks, failures);
    if (failures == 0 && numChecks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // Register port: request held one cycle, taken at the closing edge
  task wrReg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk) begin
      req.wr <= 1'b1; req.addr <= a; req.wdata <= d;
    end
    @(posedge clk) req.wr <= 1'b0;
  endtask

  task rdReg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk) begin
      req.rd <= 1'b1; req.addr <= a;
    end
    @(negedge clk) d = rdata;
    @(posedge clk) req.rd <= 1'b0;
  endtask

  // Poll the done flag; a bound keeps a dead converter from hanging the run
  task waitDone(output logic [7:0] c);
    for (int i = 0; i < 60; i++) begin
      rdReg(CtrlRegAddr, c);
      if (c[DonePos] === 1'b1) return;
    end
    failures++;
    $display("wrong value done flag expected 1 seen 0");
    wrap_up();
  endtask

  task testReset;
    rdReg(CtrlRegAddr, q); check("control reset", 10'(CtrlResetVal), 10'(q));
    rdReg(8'h80, q); check("unmapped read", 10'h000, 10'(q));
    pin <= 1'b1;
    repeat (3) @(posedge clk);
    rdReg(CtrlRegAddr, q); check("pin start", 10'h0, 10'(q[StartPos]));
    pin <= 1'b0;
    $display("test reset done");
  endtask

  task testConv(input logic ext, input logic ie, input logic [2:0] ch, input logic [10:0] vin);
    logic [9:0] exp;
    exp = (vin == 11'h000) ? 10'h000 : 10'(vin - 11'd1);
    vinLevel <= vin;
    intEnable <= ie;
    wrReg(CtrlRegAddr, {2'b00, ext, 1'b0, !ext, ch});
    if (ext) @(posedge clk) pin <= 1'b1;
    repeat (3) @(posedge clk);
    rdReg(CtrlRegAddr, q); check("busy", 10'h1, 10'(q[StartPos]));
    check("channel", 10'(ch), 10'(muxSel));
    check("port select", 10'(8'h01 << ch), 10'(portSel));
    repeat (25) @(posedge clk);
    clkEn <= 1'b0;
    repeat (3) @(posedge clk);
    clkEn <= 1'b1;
    waitDone(q);
    check("busy end", 10'h0, 10'(q[StartPos]));
    check("irq", 10'(ie), 10'(irq));
    rdReg(ResultHighAddr, r);
    check("result", exp, {r, q[7:6]});
    // Start and a one in the done bit together: neither may take
    wrReg(CtrlRegAddr, 8'h18);
    repeat (2) @(posedge clk);
    rdReg(CtrlRegAddr, q); check("start blocked", 10'h1, 10'({q[StartPos], q[DonePos]}));
    wrReg(CtrlRegAddr, 8'h00);
    pin <= 1'b0;
    rdReg(CtrlRegAddr, q); check("done clear", 10'h0, 10'(q[DonePos]));
    $display("test conversion done");
  endtask

  task testIdle;
    wrReg(CtrlRegAddr, 8'h08);
    repeat (20) @(posedge clk);
    // Start and channel write while busy: both must be refused
    wrReg(CtrlRegAddr, 8'h0b);
    // Let the write edge pass so the register has had its chance to move
    @(posedge clk);
    check("channel held", 10'h000, 10'(muxSel));
    idleMode <= 1'b1;
    repeat (2) @(posedge clk);
    idleMode <= 1'b0;
    rdReg(CtrlRegAddr, q); check("abort", 10'h0, 10'({q[StartPos], q[DonePos]}));
    $display("test idle done");
  endtask

  // Reset two cycles, then the scenarios in order
  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    testReset();
    testConv(1'b0, 1'b1, 3'd5, 11'h156);
    testConv(1'b1, 1'b0, 3'd2, 11'h000);
    testConv(1'b1, 1'b1, 3'd7, 11'h400);
    testIdle();
    wrap_up();
  end
endmodule
